/* rtl/sbst_tap.sv */
// sbst_tap: boundary-scan test access port of the synchronous memory
module sbst_tap #(
    parameter int BSR_LEN = sbst_pkg::BSR_LEN,
    parameter int Q_WIDTH = sbst_pkg::MEM_Q_WIDTH,
    parameter logic [2:0] ID_REVISION = 3'h5, // arbitrary value
    parameter logic [16:0] ID_PART = 17'h0a5c, // arbitrary value
    parameter logic [10:0] ID_VENDOR = 11'h2b5 // arbitrary value
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic tck_pin,
    input wire logic tms_pin,
    input wire logic tdi_pin,
    output logic tdo_out,
    output logic tdo_oe,
    input wire logic [BSR_LEN-1:0] pins_in,
    output logic [BSR_LEN-1:0] bsr_drive,
    output logic extest_active,
    input wire logic [Q_WIDTH-1:0] core_q_oe,
    output logic [Q_WIDTH-1:0] mem_q_oe
);

    // ==========================================================
    // pin synchronisers
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic [BSR_LEN-1:0] pins_s;
    logic tck_prev_reg;
    logic tck_rise;
    logic tck_fall;

    // tck idles low (tied low when unused); its flops start low so release makes no edge
    sbst_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_tck_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .async_in(tck_pin),
        .sync_out(tck_s)
    );

    // undriven tms/tdi pads carry pull-ups; sync flops idle high too
    sbst_sync #(.WIDTH(2), .RESET_VAL(sbst_pkg::PIN_IDLE_VAL)) u_ctl_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .async_in({tms_pin, tdi_pin}),
        .sync_out({tms_s, tdi_s})
    );

    sbst_sync #(.WIDTH(BSR_LEN), .RESET_VAL(1'b0)) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .async_in(pins_in),
        .sync_out(pins_s)
    );

    // edge finder on the synchronised test clock; starts low like a tied tck
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tck_prev_reg <= 1'b0;
        end else if (ce) begin
            tck_prev_reg <= tck_s;
        end
    end

    assign tck_rise = ce & tck_s & ~tck_prev_reg;
    assign tck_fall = ce & ~tck_s & tck_prev_reg;

    // ==========================================================
    // controller state machine
    sbst_pkg::sbst_state_e state_reg;
    sbst_pkg::sbst_state_e state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sbst_pkg::TAP_RESET: state_next = tms_s ? sbst_pkg::TAP_RESET : sbst_pkg::TAP_IDLE;
            sbst_pkg::TAP_IDLE: state_next = tms_s ? sbst_pkg::TAP_SELECT_DR : sbst_pkg::TAP_IDLE;
            sbst_pkg::TAP_SELECT_DR: begin
                state_next = tms_s ? sbst_pkg::TAP_SELECT_IR : sbst_pkg::TAP_CAPTURE_DR;
            end
            sbst_pkg::TAP_CAPTURE_DR: begin
                state_next = tms_s ? sbst_pkg::TAP_EXIT1_DR : sbst_pkg::TAP_SHIFT_DR;
            end
            sbst_pkg::TAP_SHIFT_DR: begin
                state_next = tms_s ? sbst_pkg::TAP_EXIT1_DR : sbst_pkg::TAP_SHIFT_DR;
            end
            sbst_pkg::TAP_EXIT1_DR: begin
                state_next = tms_s ? sbst_pkg::TAP_UPDATE_DR : sbst_pkg::TAP_PAUSE_DR;
            end
            sbst_pkg::TAP_PAUSE_DR: begin
                state_next = tms_s ? sbst_pkg::TAP_EXIT2_DR : sbst_pkg::TAP_PAUSE_DR;
            end
            sbst_pkg::TAP_EXIT2_DR: begin
                state_next = tms_s ? sbst_pkg::TAP_UPDATE_DR : sbst_pkg::TAP_SHIFT_DR;
            end
            sbst_pkg::TAP_UPDATE_DR: begin
                state_next = tms_s ? sbst_pkg::TAP_SELECT_DR : sbst_pkg::TAP_IDLE;
            end
            sbst_pkg::TAP_SELECT_IR: begin
                state_next = tms_s ? sbst_pkg::TAP_RESET : sbst_pkg::TAP_CAPTURE_IR;
            end
            sbst_pkg::TAP_CAPTURE_IR: begin
                state_next = tms_s ? sbst_pkg::TAP_EXIT1_IR : sbst_pkg::TAP_SHIFT_IR;
            end
            sbst_pkg::TAP_SHIFT_IR: begin
                state_next = tms_s ? sbst_pkg::TAP_EXIT1_IR : sbst_pkg::TAP_SHIFT_IR;
            end
            sbst_pkg::TAP_EXIT1_IR: begin
                state_next = tms_s ? sbst_pkg::TAP_UPDATE_IR : sbst_pkg::TAP_PAUSE_IR;
            end
            sbst_pkg::TAP_PAUSE_IR: begin
                state_next = tms_s ? sbst_pkg::TAP_EXIT2_IR : sbst_pkg::TAP_PAUSE_IR;
            end
            sbst_pkg::TAP_EXIT2_IR: begin
                state_next = tms_s ? sbst_pkg::TAP_UPDATE_IR : sbst_pkg::TAP_SHIFT_IR;
            end
            sbst_pkg::TAP_UPDATE_IR: begin
                state_next = tms_s ? sbst_pkg::TAP_SELECT_DR : sbst_pkg::TAP_IDLE;
            end
            default: state_next = sbst_pkg::TAP_RESET;
        endcase
    end

    // power-up reset lands in test-logic-reset; no separate test reset pin
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= sbst_pkg::TAP_RESET;
        end else if (tck_rise) begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // instruction register and decode
    logic [2:0] ir_shift_reg;
    logic [2:0] ir_reg;
    logic sel_id;
    logic sel_bsr;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ir_shift_reg <= sbst_pkg::IR_RESET_VAL;
        end else if (tck_rise) begin
            if (state_reg == sbst_pkg::TAP_CAPTURE_IR) begin
                ir_shift_reg <= sbst_pkg::IR_CAPTURE_VAL;
            end else if (state_reg == sbst_pkg::TAP_SHIFT_IR) begin
                ir_shift_reg <= {tdi_s, ir_shift_reg[2:1]};
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ir_reg <= sbst_pkg::IR_RESET_VAL;
        end else if (tck_rise) begin
            if (state_next == sbst_pkg::TAP_RESET) begin
                ir_reg <= sbst_pkg::IR_RESET_VAL;
            end else if (state_reg == sbst_pkg::TAP_UPDATE_IR) begin
                ir_reg <= ir_shift_reg;
            end
        end
    end

    // reserved codes fall through to bypass, the safe single-bit path
    always_comb begin
        sel_id = 1'b0;
        sel_bsr = 1'b0;
        case (ir_reg)
            sbst_pkg::INS_IDCODE: sel_id = 1'b1;
            sbst_pkg::INS_EXTEST: sel_bsr = 1'b1;
            sbst_pkg::INS_SAMPLE_Z: sel_bsr = 1'b1;
            sbst_pkg::INS_SAMPLE: sel_bsr = 1'b1;
            default: sel_bsr = 1'b0;
        endcase
    end

    // ==========================================================
    // data registers
    logic bypass_reg;
    logic [sbst_pkg::ID_LEN-1:0] id_reg;
    logic [sbst_pkg::ID_LEN-1:0] id_value;
    logic [BSR_LEN-1:0] bsr_reg;
    logic cap_dr;
    logic shift_dr;

    assign id_value = {ID_REVISION, ID_PART, ID_VENDOR, sbst_pkg::ID_PRESENT_VAL};
    assign cap_dr = tck_rise & (state_reg == sbst_pkg::TAP_CAPTURE_DR);
    assign shift_dr = tck_rise & (state_reg == sbst_pkg::TAP_SHIFT_DR);

    // bypass clears at capture and on a bypass update-ir, takes tdi only in shift, so it keeps the last tdi bit afterwards
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bypass_reg <= sbst_pkg::BYPASS_RESET_VAL;
        end else if (tck_rise && state_reg == sbst_pkg::TAP_UPDATE_IR
                     && ir_shift_reg == sbst_pkg::INS_BYPASS) begin
            bypass_reg <= sbst_pkg::BYPASS_RESET_VAL;
        end else if (cap_dr && !sel_id && !sel_bsr) begin
            bypass_reg <= sbst_pkg::BYPASS_RESET_VAL;
        end else if (shift_dr && !sel_id && !sel_bsr) begin
            bypass_reg <= tdi_s;
        end
    end

    // tdi enters the top stage, bit 0 leaves first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            id_reg <= '0;
        end else if (cap_dr && sel_id) begin
            id_reg <= id_value;
        end else if (shift_dr && sel_id) begin
            id_reg <= {tdi_s, id_reg[sbst_pkg::ID_LEN-1:1]};
        end
    end

    // boundary chain: capture all pins, then shift between tdi and tdo
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bsr_reg <= '0;
        end else if (cap_dr && sel_bsr) begin
            bsr_reg <= pins_s;
        end else if (shift_dr && sel_bsr) begin
            bsr_reg <= {tdi_s, bsr_reg[BSR_LEN-1:1]};
        end
    end

    // preload lands in the drive latches on update
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bsr_drive <= '0;
        end else if (tck_rise && state_reg == sbst_pkg::TAP_UPDATE_DR && sel_bsr) begin
            bsr_drive <= bsr_reg;
        end
    end

    // ==========================================================
    // pin control
    logic hold_hiz;

    assign hold_hiz = (ir_reg == sbst_pkg::INS_SAMPLE_Z);
    assign extest_active = (ir_reg == sbst_pkg::INS_EXTEST);
    // sample-z kills every data driver; sample/preload leaves them alone
    assign mem_q_oe = hold_hiz ? '0 : core_q_oe;

    // ==========================================================
    // test data output, moved only on falling tck
    logic tdo_bit;
    logic in_shift;

    assign in_shift = (state_reg == sbst_pkg::TAP_SHIFT_DR)
                      || (state_reg == sbst_pkg::TAP_SHIFT_IR);

    always_comb begin
        if (state_reg == sbst_pkg::TAP_SHIFT_IR) begin
            tdo_bit = ir_shift_reg[0];
        end else if (sel_id) begin
            tdo_bit = id_reg[0];
        end else if (sel_bsr) begin
            tdo_bit = bsr_reg[0];
        end else begin
            tdo_bit = bypass_reg;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tdo_out <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_out <= in_shift ? tdo_bit : 1'b0;
            tdo_oe <= in_shift;
        end
    end

    // ==========================================================
    // checks
    sample_z_hiz_a: assert property (@(posedge clk) disable iff (reset)
        (ir_reg == sbst_pkg::INS_SAMPLE_Z) |-> (mem_q_oe == '0))
        else $error("data outputs driven during sample-z");

    sample_drive_a: assert property (@(posedge clk) disable iff (reset)
        (ir_reg == sbst_pkg::INS_SAMPLE) |-> (mem_q_oe == core_q_oe))
        else $error("data outputs disturbed during sample/preload");

    bsr_capture_a: assert property (@(posedge clk) disable iff (reset)
        (cap_dr && ir_reg == sbst_pkg::INS_SAMPLE_Z) |=> (bsr_reg == $past(pins_s)))
        else $error("boundary capture missed pin values");

    id_capture_a: assert property (@(posedge clk) disable iff (reset)
        (cap_dr && ir_reg == sbst_pkg::INS_IDCODE) |=> (id_reg[0] == 1'b1)
        && (id_reg[31:29] == ID_REVISION) && (id_reg[11:1] == ID_VENDOR))
        else $error("id capture value wrong");

    id_shift_a: assert property (@(posedge clk) disable iff (reset)
        (shift_dr && ir_reg == sbst_pkg::INS_IDCODE)
        |=> (id_reg[31] == $past(tdi_s)) && (id_reg[30:0] == $past(id_reg[31:1])))
        else $error("id register did not shift tdi in");

    bypass_clear_a: assert property (@(posedge clk) disable iff (reset)
        (tck_rise && state_reg == sbst_pkg::TAP_UPDATE_IR && ir_shift_reg == 3'h7)
        |=> (bypass_reg == 1'b0) && (ir_reg == 3'h7))
        else $error("bypass not cleared on activation");

    bypass_hold_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == sbst_pkg::TAP_EXIT1_DR) |=> $stable(bypass_reg))
        else $error("bypass lost its bit after shift");

    tlr_ir_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == sbst_pkg::TAP_RESET) |-> (ir_reg == sbst_pkg::INS_IDCODE))
        else $error("instruction not reset in test-logic-reset");

    tdo_fall_a: assert property (@(posedge clk) disable iff (reset)
        $changed(tdo_oe) || $changed(tdo_out) |-> $past(tck_fall))
        else $error("tdo moved off a falling tck");

    tdo_bypass_a: assert property (@(posedge clk) disable iff (reset)
        (tck_fall && state_reg == sbst_pkg::TAP_SHIFT_DR && ir_reg == 3'h7)
        |=> tdo_oe && (tdo_out == $past(bypass_reg)))
        else $error("tdo does not show bypass in shift");

endmodule

/* rtl/sbst_pkg.sv */
// sbst_pkg: shared constants and types of the boundary-scan test access port
package sbst_pkg;

    // ==========================================================
    // register lengths
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    localparam int BSR_LEN = 107;
    localparam int MEM_Q_WIDTH = 36;

    // ==========================================================
    // instruction codes
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    // fixed pattern loaded into the instruction register at capture
    localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;

    // ==========================================================
    // identification register fields
    localparam int ID_REV_MSB = 31;
    localparam int ID_REV_LSB = 29;
    localparam int ID_PART_MSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_VEND_MSB = 11;
    localparam int ID_VEND_LSB = 1;
    localparam int ID_PRESENT_BIT = 0;
    localparam logic ID_PRESENT_VAL = 1'b1;

    // ==========================================================
    // reset values
    localparam logic [2:0] IR_RESET_VAL = 3'h1;
    localparam logic BYPASS_RESET_VAL = 1'b0;
    localparam logic PIN_IDLE_VAL = 1'b1;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // tap controller states, standard encoding
    typedef enum logic [3:0] {
        TAP_EXIT2_DR = 4'b0000,
        TAP_EXIT1_DR = 4'b0001,
        TAP_SHIFT_DR = 4'b0010,
        TAP_PAUSE_DR = 4'b0011,
        TAP_SELECT_IR = 4'b0100,
        TAP_UPDATE_DR = 4'b0101,
        TAP_CAPTURE_DR = 4'b0110,
        TAP_SELECT_DR = 4'b0111,
        TAP_EXIT2_IR = 4'b1000,
        TAP_EXIT1_IR = 4'b1001,
        TAP_SHIFT_IR = 4'b1010,
        TAP_PAUSE_IR = 4'b1011,
        TAP_IDLE = 4'b1100,
        TAP_UPDATE_IR = 4'b1101,
        TAP_CAPTURE_IR = 4'b1110,
        TAP_RESET = 4'b1111
    } sbst_state_e;

endpackage

/* rtl/sbst_sync.sv */
// sbst_sync: two-stage synchroniser for a group of pin inputs
module sbst_sync #(
    parameter int WIDTH = 1,
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // first stage is read only by the second stage
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_reg <= {WIDTH{RESET_VAL}};
            sync_out <= {WIDTH{RESET_VAL}};
        end else if (ce) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

/* bench/sbst_tester.sv */
// sbst_tester: behavioural boundary-scan tester that drives the test port pins
module sbst_tester (
    input wire logic clk,
    output logic tck_pin,
    output logic tms_pin,
    output logic tdi_pin,
    input wire logic tdo_out,
    input wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic last_tdo = 1'b0;
    logic tdo_w;
    logic oe_seen = 1'b0;

    // a released tdo floats: show the inverse of the last driven bit, never a kind value
    always @(posedge clk) if (tdo_oe) last_tdo <= tdo_out;
    assign tdo_w = tdo_oe ? tdo_out : ~last_tdo;

    // pads idle high as with a pull-up; tck parked low outside frames
    initial begin
        tck_pin = 1'b0;
        tms_pin = 1'b1;
        tdi_pin = 1'b1;
    end

    // ==========================================================
    // one tck period: 80 ns low with tms/tdi set early, then 80 ns high
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clk);
        #1;
        tms_pin = m;
        tdi_pin = d;
        repeat (7) @(posedge clk);
        #1;
        o = tdo_w; // sampled late in the low phase, well after the falling edge update
        oe_seen = tdo_oe;
        tck_pin = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        tck_pin = 1'b0;
    endtask

    // instruction scan from idle back to idle, lsb first
    task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
        logic o;
        step(1'b1, 1'b1, o);
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < 3; i++) begin
            step(i == 2, code[i], o);
            cap[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask

    // data scan of n bits from idle back to idle; oe_ok tells whether tdo was driven throughout
    task automatic shift_dr(input int n, input logic [127:0] din, output logic [127:0] dout,
                            output logic oe_ok);
        logic o;
        dout = '0;
        oe_ok = 1'b1;
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
            oe_ok = oe_ok & oe_seen;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
endmodule

/* bench/sbst_tap_tb_top.sv */
// sbst_tap_tb_top: self-checking bench of the boundary-scan test access port
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module sbst_tap_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int NB = sbst_pkg::BSR_LEN;
    localparam logic [2:0] T_REV = 3'h3; // arbitrary value
    localparam logic [16:0] T_PART = 17'h1b2d4; // arbitrary value
    localparam logic [10:0] T_VEND = 11'h5a6; // arbitrary value
    localparam logic [31:0] ID_EXP = {T_REV, T_PART, T_VEND, 1'b1};
    localparam logic [127:0] PAT_A = {4{32'h9c3a_5e17}};
    localparam logic [127:0] PAT_B = {4{32'h6b0d_f248}};
    localparam logic [35:0] CORE_OE = 36'h9_a5c3_0f1e;

    logic clk;
    logic reset;
    logic ce;
    logic tck_pin;
    logic tms_pin;
    logic tdi_pin;
    logic tdo_out;
    logic tdo_oe;
    logic [NB-1:0] pins_in;
    logic [NB-1:0] bsr_drive;
    logic extest_active;
    logic [35:0] core_q_oe;
    logic [35:0] mem_q_oe;
    int n_fail = 0;
    int n_checks = 0;

    sbst_tap #(.ID_REVISION(T_REV), .ID_PART(T_PART), .ID_VENDOR(T_VEND)) u_dut (
        .clk(clk), .reset(reset), .ce(ce), .tck_pin(tck_pin), .tms_pin(tms_pin),
        .tdi_pin(tdi_pin), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .pins_in(pins_in),
        .bsr_drive(bsr_drive), .extest_active(extest_active), .core_q_oe(core_q_oe),
        .mem_q_oe(mem_q_oe)
    );

    sbst_tester u_tester (
        .clk(clk), .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_pin(tdi_pin),
        .tdo_out(tdo_out), .tdo_oe(tdo_oe)
    );

    // ==========================================================
    // clock and closing report
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    // ==========================================================
    // scenarios
    task automatic sc_power_up();
        `CHK("tdo_oe", 1'b0, tdo_oe)
        `CHK("extest_active", 1'b0, extest_active)
        `CHK("mem_q_oe", CORE_OE, mem_q_oe)
        `CHK("bsr_drive", {NB{1'b0}}, bsr_drive)
    endtask

    // identification is the instruction after reset; 64 bits show id then the shifted-in data
    // the controller sits in test-logic-reset here, so one tms-low tick brings it to idle
    task automatic sc_idcode();
        logic [127:0] dout;
        logic oe_ok;
        logic o;
        u_tester.step(1'b0, 1'b1, o);
        u_tester.shift_dr(64, PAT_B, dout, oe_ok);
        `CHK("id value", ID_EXP, dout[31:0])
        `CHK("id passthrough", PAT_B[31:0], dout[63:32])
        `CHK("tdo driven in shift", 1'b1, oe_ok)
        `CHK("tdo released", 1'b0, tdo_oe)
    endtask

    // each defined code: capture pattern, pin effects, one-bit path for bypass; reserved codes skipped
    task automatic sc_codes();
        logic [2:0] cap;
        logic [127:0] dout;
        logic oe_ok;
        logic [2:0] c;
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            // a well-behaved tester never loads the reserved codes
            if (c == 3'h3 || c == 3'h5 || c == 3'h6) continue;
            u_tester.load_ir(c, cap);
            `CHK("ir capture", sbst_pkg::IR_CAPTURE_VAL, cap)
            `CHK("extest_active", (c == sbst_pkg::INS_EXTEST), extest_active)
            `CHK("mem_q_oe", (c == sbst_pkg::INS_SAMPLE_Z) ? 36'h0 : CORE_OE, mem_q_oe)
            if (c == sbst_pkg::INS_BYPASS) begin
                u_tester.shift_dr(2, 128'h3, dout, oe_ok);
                `CHK("bypass path", 2'b10, dout[1:0])
            end
        end
    endtask

    // bypass left holding 1, reloaded, then pause in mid-scan
    task automatic sc_bypass_hold();
        logic [2:0] cap;
        logic a;
        logic b;
        logic o;
        u_tester.load_ir(sbst_pkg::INS_BYPASS, cap);
        u_tester.step(1'b1, 1'b1, o);
        u_tester.step(1'b0, 1'b1, o);
        u_tester.step(1'b0, 1'b1, o);
        u_tester.step(1'b1, 1'b1, a);
        u_tester.step(1'b0, 1'b0, o);
        u_tester.step(1'b1, 1'b0, o);
        u_tester.step(1'b0, 1'b0, o);
        u_tester.step(1'b1, 1'b0, b);
        u_tester.step(1'b1, 1'b0, o);
        u_tester.step(1'b0, 1'b0, o);
        `CHK("bypass cleared", 1'b0, a)
        `CHK("bypass retained", 1'b1, b)
    endtask

    // sample with tristate, then sample/preload, then external test
    task automatic sc_boundary();
        logic [2:0] cap;
        logic [127:0] dout;
        logic oe_ok;
        pins_in = PAT_A[NB-1:0];
        u_tester.load_ir(sbst_pkg::INS_SAMPLE_Z, cap);
        `CHK("q tristated", 36'h0, mem_q_oe)
        u_tester.shift_dr(NB, PAT_B, dout, oe_ok);
        `CHK("sample_z capture", PAT_A[NB-1:0], dout[NB-1:0])
        pins_in = PAT_B[NB-1:0];
        u_tester.load_ir(sbst_pkg::INS_SAMPLE, cap);
        `CHK("q driven", CORE_OE, mem_q_oe)
        u_tester.shift_dr(NB, PAT_A, dout, oe_ok);
        `CHK("sample capture", PAT_B[NB-1:0], dout[NB-1:0])
        `CHK("preload", PAT_A[NB-1:0], bsr_drive)
        u_tester.load_ir(sbst_pkg::INS_EXTEST, cap);
        `CHK("extest_active", 1'b1, extest_active)
        `CHK("preload kept", PAT_A[NB-1:0], bsr_drive)
    endtask

    // ce low freezes the port: a whole instruction scan leaves no trace
    task automatic sc_ce_freeze();
        logic [2:0] cap;
        ce = 1'b0;
        u_tester.load_ir(sbst_pkg::INS_SAMPLE_Z, cap);
        `CHK("frozen extest_active", 1'b1, extest_active)
        `CHK("frozen mem_q_oe", CORE_OE, mem_q_oe)
        ce = 1'b1;
        u_tester.load_ir(sbst_pkg::INS_SAMPLE_Z, cap);
        `CHK("thawed mem_q_oe", 36'h0, mem_q_oe)
        `CHK("thawed extest_active", 1'b0, extest_active)
    endtask

    // reset in mid-run returns to the power-up state
    task automatic sc_second_reset();
        reset = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (3) @(posedge clk);
        sc_power_up();
        sc_idcode();
    endtask

    // ==========================================================
    // main sequence; ce held high except while sc_ce_freeze drives it low
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        pins_in = '0;
        core_q_oe = CORE_OE;
        repeat (10) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (3) @(posedge clk);
        sc_power_up();
        sc_idcode();
        sc_codes();
        sc_bypass_hold();
        sc_boundary();
        sc_ce_freeze();
        sc_second_reset();
        end_sim();
    end
endmodule
